// >>> hdl/startup_seq_pkg.sv
// Constants and types shared by the multi-phase startup sequencer
package startup_seq_pkg;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int NUM_PHASES         = 6;
  localparam int SENSED_PHASES      = 5;
  localparam int CODE_W             = 8;
  localparam int TIMER_W            = 24;
  localparam int COUNT_W            = 3;
  // Timer intervals, as printed
  localparam int ENABLE_DELAY_NS    = 2000000;
  localparam int BOOT_HOLD_NS       = 2000000;
  localparam int PG_BLANK_NS        = 2000000;
  localparam int PG_MASK_NS         = 100000;
  localparam int OV_STATIC_NS       = 400;
  localparam int OV_CHANGING_NS     = 100000;
  // Least times round up, longest times round down
  localparam int ENABLE_DELAY_CYC   = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_HOLD_CYC      = (BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PG_BLANK_CYC       = (PG_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PG_MASK_CYC        = (PG_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_STATIC_CYC      = OV_STATIC_NS / CLK_PERIOD_NS;
  localparam int OV_CHANGING_CYC    = OV_CHANGING_NS / CLK_PERIOD_NS;
  // Target code: linear, 6.25 mV per step, zero is off
  localparam int CODE_LSB_UV        = 6250;
  localparam int BOOT_MV            = 1100;
  localparam logic [CODE_W-1:0] BOOT_CODE = CODE_W'(BOOT_MV * 1000 / CODE_LSB_UV);
  localparam logic [CODE_W-1:0] ZERO_CODE = 8'h00;
  // Soft-start slew of 0.5 V/ms gives one code step per RAMP_STEP_CYC
  localparam int SS_SLEW_UV_PER_US  = 500;
  localparam int RAMP_STEP_NS       = CODE_LSB_UV * 1000 / SS_SLEW_UV_PER_US;
  localparam int RAMP_STEP_CYC      = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_TICKS       = 6;
  localparam logic [SENSED_PHASES-1:0] NO_PINS_HIGH = 5'h00;
  localparam logic [NUM_PHASES-1:0]    ALL_PHASES   = 6'h3F;

  typedef enum logic [3:0] {
    ST_IDLE, ST_EN_DELAY, ST_DETECT, ST_SOFT_START, ST_BOOT_HOLD,
    ST_FINAL_RAMP, ST_PG_MASK, ST_PG_BLANK, ST_RUN
  } seq_state_type;
endpackage

// >>> hdl/multiphase_startup_sequencer.sv
// Startup sequencer, phase detection and phase output control
// Overview of operation
// R1 - Enable delay of 2 ms after qualification
// R2 - First six master ticks detect phases only
// R3 - Soft-start ramps target up to 1.1 V
// R4 - Hold boot level for 2 ms
// R5 - Sample code, ramp to final level
// R6 - Mask then blank power-good before asserting
// R7 - Six phases default; high pins drop count; code drops only the high pins contiguous from the sixth down
// R8 - Weak sink on pins two-six before soft-start
// R9 - Sensed high means unused, low active; code treats a high pin below a low pin as active
// R10 - First phase output low during detection
// R11 - Active pins lose sink, run as PWM
// R12 - Unused pins lose sink, go high-impedance
// R13 - Per-phase rate is master divided by count
// R14 - Each phase gated independently, overlap allowed
// R15 - Power-good blank lasts 2 ms
// R16 - Overvoltage forces outputs low after delay
// R17 - Loss of enable or supply restarts sequence
`timescale 1ns/100ps
module multiphase_startup_sequencer
  import startup_seq_pkg::*;
#(
  parameter int ENABLE_DELAY   = startup_seq_pkg::ENABLE_DELAY_CYC,
  parameter int BOOT_HOLD      = startup_seq_pkg::BOOT_HOLD_CYC,
  parameter int PG_BLANK       = startup_seq_pkg::PG_BLANK_CYC,
  parameter int PG_MASK        = startup_seq_pkg::PG_MASK_CYC,
  parameter int OV_CHANGING    = startup_seq_pkg::OV_CHANGING_CYC,
  parameter int RAMP_STEP      = startup_seq_pkg::RAMP_STEP_CYC
)(
  input  wire logic                                     clk,
  input  wire logic                                     rst_b,
  input  wire logic                                     enable,
  input  wire logic                                     supply_lockout_ok,
  input  wire logic                                     master_tick,
  input  wire logic [startup_seq_pkg::CODE_W-1:0]       vid_code,
  input  wire logic [startup_seq_pkg::NUM_PHASES-1:0]   pwm_demand,
  input  wire logic                                     overvoltage,
  input  wire logic                                     pg_window_ok,
  input  wire logic [startup_seq_pkg::SENSED_PHASES-1:0] phase_pin_high,
  output logic [startup_seq_pkg::NUM_PHASES-1:0]        phase_out,
  output logic [startup_seq_pkg::NUM_PHASES-1:0]        phase_oe_b,
  output logic [startup_seq_pkg::SENSED_PHASES-1:0]     phase_sink_en,
  output logic [startup_seq_pkg::NUM_PHASES-1:0]        phase_tick,
  output logic [startup_seq_pkg::COUNT_W-1:0]           active_count,
  output logic [startup_seq_pkg::CODE_W-1:0]            target_code,
  output logic                                          power_good_out,
  output logic                                          crowbar_active
);
  import startup_seq_pkg::*;

  // Active phases: six minus the pins held high contiguously from the sixth down
  function automatic logic [COUNT_W-1:0] count_active(input logic [SENSED_PHASES-1:0] high);
    logic [COUNT_W-1:0] n;
    logic               run;
    n   = COUNT_W'(NUM_PHASES);
    run = 1'b1;
    for (int k = SENSED_PHASES - 1; k >= 0; k--)
    begin
      run = run & high[k];
      if (run)
        n = n - 3'h1; // see R7
    end
    return n;
  endfunction

  // One bit per phase below the active count
  function automatic logic [NUM_PHASES-1:0] active_mask(input logic [COUNT_W-1:0] n);
    logic [NUM_PHASES-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PHASES; i++)
      m[i] = (COUNT_W'(i) < n);
    return m;
  endfunction

  localparam logic [TIMER_W-1:0] EN_DELAY_LAST  = TIMER_W'(ENABLE_DELAY - 1);
  localparam logic [TIMER_W-1:0] BOOT_HOLD_LAST = TIMER_W'(BOOT_HOLD - 1);
  localparam logic [TIMER_W-1:0] PG_BLANK_LAST  = TIMER_W'(PG_BLANK - 1);
  localparam logic [TIMER_W-1:0] PG_MASK_LAST   = TIMER_W'(PG_MASK - 1);
  localparam logic [TIMER_W-1:0] STEP_LAST      = TIMER_W'(RAMP_STEP - 1);
  localparam logic [TIMER_W-1:0] OV_STAT_LAST   = TIMER_W'(OV_STATIC_CYC - 1);
  localparam logic [TIMER_W-1:0] OV_CHG_LAST    = TIMER_W'(OV_CHANGING - 1);
  localparam logic [2:0]         DETECT_LAST    = 3'(DETECT_TICKS - 1);

  seq_state_type            state_q, state_d;
  logic [TIMER_W-1:0]       timer_q, timer_d;
  logic [TIMER_W-1:0]       step_q, step_d;
  logic [TIMER_W-1:0]       dly_q, dly_d;
  logic [2:0]               det_q, det_d;
  logic [SENSED_PHASES-1:0] high_q, high_d;
  logic [CODE_W-1:0]        goal_q, goal_d;
  logic [CODE_W-1:0]        target_q, target_d;
  logic [COUNT_W-1:0]       count_q, count_d;
  logic                     qualified;
  logic                     step_due;
  logic                     changing;

  assign qualified = enable & supply_lockout_ok;
  assign step_due  = (step_q == STEP_LAST);
  assign changing  = (state_q == ST_SOFT_START) || (state_q == ST_FINAL_RAMP)
                     || ((state_q == ST_RUN) && (target_q != goal_q));

  // Sequencer next state, timers, detection and target ramp
  always_comb
  begin
    state_d  = state_q;
    timer_d  = timer_q + 24'h000001;
    step_d   = step_due ? '0 : step_q + 24'h000001;
    dly_d    = (state_q == ST_EN_DELAY) ? dly_q + 24'h000001 : '0; // Separate delay count
    det_d    = det_q;
    high_d   = high_q;
    goal_d   = goal_q;
    target_d = target_q;
    count_d  = count_q;
    case (state_q)
      ST_IDLE:
      begin
        timer_d  = '0;
        target_d = ZERO_CODE;
        if (qualified)
          state_d = ST_EN_DELAY;
      end
      ST_EN_DELAY:
        if (timer_q == EN_DELAY_LAST) // see R1
        begin
          state_d = ST_DETECT;
          det_d   = '0;
          high_d  = NO_PINS_HIGH;
        end
      ST_DETECT:
        if (master_tick)
        begin
          high_d = phase_pin_high; // see R9
          det_d  = det_q + 3'h1;
          if (det_q == DETECT_LAST) // see R2
          begin
            count_d = count_active(phase_pin_high); // see R7
            state_d = ST_SOFT_START;
            step_d  = '0;
          end
        end
      ST_SOFT_START:
      begin
        timer_d = '0;
        if (target_q == BOOT_CODE)
          state_d = ST_BOOT_HOLD;
        else if (step_due)
          target_d = target_q + 8'h01; // see R3
      end
      ST_BOOT_HOLD:
        if (timer_q == BOOT_HOLD_LAST) // see R4
        begin
          goal_d  = vid_code; // see R5
          state_d = ST_FINAL_RAMP;
          step_d  = '0;
        end
      ST_FINAL_RAMP:
      begin
        timer_d = '0;
        if (target_q == goal_q)
          state_d = ST_PG_MASK;
        else if (step_due)
          target_d = (target_q < goal_q) ? target_q + 8'h01 : target_q - 8'h01; // see R5
      end
      ST_PG_MASK:
        if (timer_q == PG_MASK_LAST) // see R6
        begin
          state_d = ST_PG_BLANK;
          timer_d = '0;
        end
      ST_PG_BLANK:
        if (timer_q == PG_BLANK_LAST) // see R15
          state_d = ST_RUN;
      ST_RUN:
      begin
        timer_d = '0;
        goal_d  = vid_code;
        if (target_q != goal_q && step_due)
          target_d = (target_q < goal_q) ? target_q + 8'h01 : target_q - 8'h01;
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (!qualified) // see R17
    begin
      state_d  = ST_IDLE;
      target_d = ZERO_CODE;
      timer_d  = '0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q  <= ST_IDLE;
      timer_q  <= '0;
      step_q   <= '0;
      dly_q    <= '0;
      det_q    <= '0;
      high_q   <= NO_PINS_HIGH;
      goal_q   <= ZERO_CODE;
      target_q <= ZERO_CODE;
      count_q  <= COUNT_W'(NUM_PHASES);
    end
    else
    begin
      state_q  <= state_d;
      timer_q  <= timer_d;
      step_q   <= step_d;
      dly_q    <= dly_d;
      det_q    <= det_d;
      high_q   <= high_d;
      goal_q   <= goal_d;
      target_q <= target_d;
      count_q  <= count_d;
    end
  end

  // Crowbar: overvoltage held for the delay forces outputs low
  logic [TIMER_W-1:0] ov_q, ov_d;
  logic               crow_q, crow_d;

  always_comb
  begin
    ov_d   = '0;
    crow_d = crow_q & overvoltage;
    if (overvoltage && !crow_q)
    begin
      ov_d = ov_q + 24'h000001;
      if (ov_q >= (changing ? OV_CHG_LAST : OV_STAT_LAST)) // see R16
        crow_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ov_q   <= '0;
      crow_q <= 1'b0;
    end
    else
    begin
      ov_q   <= ov_d;
      crow_q <= crow_d;
    end
  end

  // Phase pins, sinks, per-phase ticks and power-good
  logic [NUM_PHASES-1:0]    out_q, out_d, oe_b_q, oe_b_d, tick_q, tick_d;
  logic [SENSED_PHASES-1:0] sink_q, sink_d;
  logic [COUNT_W-1:0]       rot_q, rot_d;
  logic                     pg_q, pg_d;
  logic                     pwm_phase;
  logic                     pre_soft;
  logic [NUM_PHASES-1:0]    act;

  assign pwm_phase = (state_q != ST_IDLE) && (state_q != ST_EN_DELAY) && (state_q != ST_DETECT);
  assign pre_soft  = (state_q == ST_IDLE) || (state_q == ST_EN_DELAY) || (state_q == ST_DETECT);
  assign act       = active_mask(count_q);

  always_comb
  begin
    sink_d = (enable && pre_soft) ? '1 : '0; // see R8
    rot_d  = rot_q;
    tick_d = '0;
    if (master_tick && pwm_phase)
    begin
      tick_d[rot_q] = 1'b1; // see R13
      rot_d = (rot_q >= count_q - 3'h1) ? '0 : rot_q + 3'h1;
    end
    else if (!pwm_phase)
      rot_d = '0;
    for (int i = 0; i < NUM_PHASES; i++)
    begin
      out_d[i]  = pwm_phase && act[i] && !crow_q && pwm_demand[i]; // see R14
      oe_b_d[i] = 1'b1;
      if (i == 0)
        oe_b_d[i] = 1'b0; // see R10
      else if (pwm_phase)
        oe_b_d[i] = !act[i]; // see R11 see R12
      else if (state_q == ST_IDLE && !enable)
        oe_b_d[i] = !act[i]; // see R17
    end
    if (crow_q)
      oe_b_d = oe_b_d & ~act; // see R16
    pg_d = (state_q == ST_RUN) && pg_window_ok && !crow_q; // see R6
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q  <= '0;
      oe_b_q <= ALL_PHASES;
      tick_q <= '0;
      sink_q <= '0;
      rot_q  <= '0;
      pg_q   <= 1'b0;
    end
    else
    begin
      out_q  <= out_d;
      oe_b_q <= oe_b_d;
      tick_q <= tick_d;
      sink_q <= sink_d;
      rot_q  <= rot_d;
      pg_q   <= pg_d;
    end
  end

  assign phase_out      = out_q;
  assign phase_oe_b     = oe_b_q;
  assign phase_sink_en  = sink_q;
  assign phase_tick     = tick_q;
  assign active_count   = count_q;
  assign target_code    = target_q;
  assign power_good_out = pg_q;
  assign crowbar_active = crow_q;

  // Checks on the sequence and the pins
  sequence s_det_done;
    (state_q == ST_DETECT) && master_tick && (det_q == DETECT_LAST);
  endsequence
  sequence s_hold_done;
    (state_q == ST_BOOT_HOLD) && (timer_q == BOOT_HOLD_LAST) && qualified;
  endsequence

  a_en_delay_len: assert property (@(posedge clk) disable iff (!rst_b) // see R1
    (state_q == ST_EN_DELAY) ##1 (state_q == ST_DETECT) |-> dly_q == TIMER_W'(ENABLE_DELAY))
    else $error("enable delay length wrong");
  a_detect_blank: assert property (@(posedge clk) disable iff (!rst_b) // see R2
    (state_q == ST_DETECT) |=> phase_out == '0)
    else $error("phase output during detection");
  a_detect_count: assert property (@(posedge clk) disable iff (!rst_b) // see R7
    s_det_done |=> count_q == count_active(high_d) || !qualified)
    else $error("phase count wrong");
  a_boot_level: assert property (@(posedge clk) disable iff (!rst_b) // see R3
    (state_q == ST_BOOT_HOLD) |-> target_q == BOOT_CODE)
    else $error("boot level wrong");
  a_vid_sample: assert property (@(posedge clk) disable iff (!rst_b) // see R5
    s_hold_done |=> (state_q == ST_FINAL_RAMP) && (goal_q == $past(vid_code)))
    else $error("code not sampled");
  a_pg_blank: assert property (@(posedge clk) disable iff (!rst_b) // see R6
    (state_q != ST_RUN) |=> !power_good_out)
    else $error("power-good before blank end");
  a_unused_hiz: assert property (@(posedge clk) disable iff (!rst_b) // see R12
    pwm_phase |=> (phase_oe_b[NUM_PHASES-1:1] & act[NUM_PHASES-1:1]) == '0
                  && (phase_oe_b[NUM_PHASES-1:1] | act[NUM_PHASES-1:1]) == '1)
    else $error("unused pin driven");
  a_sink_pre: assert property (@(posedge clk) disable iff (!rst_b) // see R8
    enable && (state_q == ST_EN_DELAY) |=> phase_sink_en == '1)
    else $error("sink missing");
  a_crowbar_low: assert property (@(posedge clk) disable iff (!rst_b) // see R16
    crow_q |=> (phase_out & act) == '0)
    else $error("output high in crowbar");
  a_restart_idle: assert property (@(posedge clk) disable iff (!rst_b) // see R17
    !qualified |=> (state_q == ST_IDLE) && (target_q == ZERO_CODE))
    else $error("no restart on loss");
endmodule

// >>> dv/gate_driver_model.sv
// Gate driver side of the phase pins: tie options, weak sink, pin comparators
`timescale 1ns/100ps
module gate_driver_model
  import startup_seq_pkg::*;
(
  input  wire logic                                      clk,
  input  wire logic [startup_seq_pkg::SENSED_PHASES-1:0] tie_high,
  input  wire logic [startup_seq_pkg::NUM_PHASES-1:0]    phase_out,
  input  wire logic [startup_seq_pkg::NUM_PHASES-1:0]    phase_oe_b,
  input  wire logic [startup_seq_pkg::SENSED_PHASES-1:0] phase_sink_en,
  output logic      [startup_seq_pkg::SENSED_PHASES-1:0] phase_pin_high
);
  logic float_q = 1'b0;

  // Released pin with no sink and no tie wanders every cycle
  always @(posedge clk)
    float_q <= ~float_q;

  // Level seen by each pin comparator
  always_comb
  begin
    for (int i = 0; i < SENSED_PHASES; i++)
    begin
      if (tie_high[i])
        phase_pin_high[i] = 1'b1;
      else if (!phase_oe_b[i+1])
        phase_pin_high[i] = phase_out[i+1];
      else if (phase_sink_en[i])
        phase_pin_high[i] = 1'b0;
      else
        phase_pin_high[i] = float_q;
    end
  end
endmodule

// >>> dv/multiphase_startup_sequencer_tb.sv
// Self-checking bench for the multi-phase startup sequencer
`timescale 1ns/100ps
module multiphase_startup_sequencer_tb;
  import startup_seq_pkg::*;
  localparam int EN_DLY   = 50;
  localparam int OV_CYC   = 30;
  localparam int TICK_DIV = 4;
  localparam int HOLD_C   = 50;
  localparam int MASK_C   = 20;
  localparam int BLANK_C  = 50;
  localparam int RAMP_C   = 64;

  typedef struct packed {logic [4:0] tie; logic [2:0] cnt;} row_type;
  row_type rows [8] = '{'{5'h00, 3'h6}, '{5'h10, 3'h5}, '{5'h18, 3'h4}, '{5'h1C, 3'h3},
                        '{5'h1E, 3'h2}, '{5'h1F, 3'h1}, '{5'h1A, 3'h4}, '{5'h08, 3'h6}};

  logic        clk, rst_b, enable, supply_lockout_ok, master_tick, overvoltage, pg_window_ok;
  logic [7:0]  vid_code, target_code;
  logic [5:0]  pwm_demand, phase_out, phase_oe_b, phase_tick, act, oe_x;
  logic [4:0]  tie, phase_pin_high, phase_sink_en;
  logic [2:0]  active_count;
  logic        power_good_out, crowbar_active;
  int          err_total, total_checks, n, div;

  multiphase_startup_sequencer #(.ENABLE_DELAY(EN_DLY), .BOOT_HOLD(HOLD_C), .PG_BLANK(BLANK_C),
    .PG_MASK(MASK_C), .OV_CHANGING(OV_CYC), .RAMP_STEP(RAMP_C)) DUT (.clk(clk), .rst_b(rst_b),
    .enable(enable),
    .supply_lockout_ok(supply_lockout_ok), .master_tick(master_tick), .vid_code(vid_code),
    .pwm_demand(pwm_demand), .overvoltage(overvoltage), .pg_window_ok(pg_window_ok),
    .phase_pin_high(phase_pin_high), .phase_out(phase_out), .phase_oe_b(phase_oe_b),
    .phase_sink_en(phase_sink_en), .phase_tick(phase_tick), .active_count(active_count),
    .target_code(target_code), .power_good_out(power_good_out),
    .crowbar_active(crowbar_active));

  gate_driver_model drivers (.clk(clk), .tie_high(tie), .phase_out(phase_out),
    .phase_oe_b(phase_oe_b), .phase_sink_en(phase_sink_en), .phase_pin_high(phase_pin_high));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Master oscillator pulse every TICK_DIV cycles
  initial
  begin
    div = 0;
    master_tick = 1'b0;
    forever
    begin
      @(posedge clk);
      #1;
      div = (div + 1) % TICK_DIV;
      master_tick = (div == 0);
    end
  end

  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      err_total++;
      $display("Error at %0t: took %0d cycles, expected %0d", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // One cycle of a bounded wait; a spent bound ends the run
  task automatic step(inout int k, input int lim);
    wait_cyc(1);
    k++;
    if (k > lim)
    begin
      err_total++;
      $display("Error at %0t: wait limit reached", $time);
      end_sim();
    end
  endtask

  // Main sequence
  initial
  begin
    {enable, overvoltage, pg_window_ok, rst_b} = 4'h0;
    supply_lockout_ok = 1'b1;
    vid_code = 8'h80;
    pwm_demand = 6'h3F;
    tie = 5'h00;
    err_total = 0;
    total_checks = 0;
    wait_cyc(1);
    chk_val({phase_oe_b, phase_sink_en, phase_out}, 17'h1F800);
    chk_val({active_count, target_code, power_good_out, crowbar_active}, 16'h1800);
    wait_cyc(1);
    rst_b = 1'b1;
    wait_cyc(2);
    chk_val({phase_oe_b, phase_sink_en}, 11'h000);
    $display("Reset test done");
    for (int r = 0; r < 8; r++)
    begin
      enable = 1'b0;
      tie = rows[r].tie;
      wait_cyc(2);
      enable = 1'b1;
      wait_cyc(2);
      chk_val(phase_sink_en, 5'h1F);
      wait_cyc(EN_DLY);
      chk_val(phase_out, 6'h00);
      chk_val(phase_oe_b[0], 1'b0);
      n = EN_DLY + 2;
      while (phase_sink_en !== 5'h00) step(n, 200);
      chk_val(n >= EN_DLY + 3 + 5 * TICK_DIV && n <= EN_DLY + 2 + 6 * TICK_DIV, 1'b1);
      wait_cyc(2);
      act = 6'h3F >> (6 - rows[r].cnt);
      oe_x = ~act;
      chk_val(active_count, rows[r].cnt);
      chk_val(phase_oe_b, oe_x);
      chk_val(phase_out, act);
      n = 0;
      while (phase_tick[0] !== 1'b1) step(n, 60);
      n = 0;
      do step(n, 60); while (phase_tick[0] !== 1'b1);
      chk_time(n, TICK_DIV * rows[r].cnt);
      $display("Phase row %0d done", r);
    end
    // Soft-start climbs one code per ramp step
    n = 0;
    while (target_code !== 8'h01) step(n, 2000);
    n = 0;
    while (target_code !== 8'h02) step(n, 2000);
    chk_time(n, RAMP_C);
    $display("Ramp test done");
    // Overvoltage while the code moves
    overvoltage = 1'b1;
    n = 0;
    while (crowbar_active !== 1'b1) step(n, 100);
    chk_time(n, OV_CYC);
    wait_cyc(2);
    chk_val({phase_out, power_good_out}, 7'h00);
    overvoltage = 1'b0;
    wait_cyc(3);
    chk_val({crowbar_active, phase_out}, 7'h3F);
    $display("Overvoltage test done");
    // Supply lockout in mid soft-start
    supply_lockout_ok = 1'b0;
    wait_cyc(2);
    chk_val({target_code, phase_out}, 14'h0000);
    $display("Lockout test done");
    // Full sequence to power-good on a static code, then a static overvoltage
    supply_lockout_ok = 1'b1;
    pg_window_ok = 1'b1;
    n = 0;
    while (target_code !== BOOT_CODE) step(n, 12000);
    n = 0;
    while (target_code === BOOT_CODE) step(n, 200);
    chk_time(n, HOLD_C + 1 + RAMP_C);
    chk_val(target_code, 8'hAF);
    n = 0;
    while (target_code !== 8'h80) step(n, 4000);
    chk_val(power_good_out, 1'b0);
    n = 0;
    while (power_good_out !== 1'b1) step(n, 200);
    chk_time(n, MASK_C + BLANK_C + 2);
    pg_window_ok = 1'b0;
    wait_cyc(1);
    chk_val(power_good_out, 1'b0);
    pg_window_ok = 1'b1;
    overvoltage = 1'b1;
    n = 0;
    while (crowbar_active !== 1'b1) step(n, 100);
    chk_time(n, OV_STATIC_CYC);
    wait_cyc(1);
    chk_val({phase_out, power_good_out}, 7'h00);
    overvoltage = 1'b0;
    $display("Full sequence test done");
    end_sim();
  end
endmodule
